// *** core/mesf_pkg.sv ***
// Package of constants and types for the metering event status flag block.
package mesf_pkg;
    // Clock and timing figures.
    localparam int CLK_HZ          = 50_000_000;
    localparam int SAMPLE_HZ       = 8_000;
    localparam int SAMPLE_CYC      = CLK_HZ / SAMPLE_HZ;
    localparam int PULSE_LOW_NS    = 80;
    localparam int CLK_PERIOD_NS   = 20;
    localparam int PULSE_LOW_CYC   = (PULSE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICKS_PER_MS    = SAMPLE_HZ / 1000;
    // Harmonic settle times in milliseconds, one per settle-time code.
    localparam int SETTLE_MS_0     = 500;
    localparam int SETTLE_MS_1     = 750;
    localparam int SETTLE_MS_2     = 1000;
    localparam int SETTLE_MS_3     = 1250;
    // Missing zero-crossing timeout in sample ticks.
    localparam int ZX_TIMEOUT_TICKS = 255;

    // Register indices; byte address is four times the index.
    localparam logic [15:0] IDX_STATUS_FIRST  = 16'he502;
    localparam logic [15:0] IDX_STATUS_SECOND = 16'he503;
    localparam logic [15:0] IDX_MASK_FIRST    = 16'he50a;
    localparam logic [15:0] IDX_MASK_SECOND   = 16'he50b;
    localparam logic [15:0] IDX_NOLOAD_PHASE  = 16'he608;
    localparam logic [15:0] IDX_PULSE_MODE    = 16'he610;
    localparam logic [15:0] IDX_POWER_POLAR   = 16'he617;
    localparam logic [15:0] IDX_HARM_CONFIG   = 16'he900;

    // Bit positions in the first status register.
    localparam int B_PATH2_FLIP  = 13;
    localparam int B_PULSE_ONE   = 14;
    localparam int B_DSP_DONE    = 17;
    localparam int B_PATH3_FLIP  = 18;
    localparam int B_HARM_UPDATE = 19;
    localparam logic [31:0] STATUS_FIRST_USED = 32'h000f_e000;
    // Bit positions in the second status register.
    localparam int B_TOTAL_NL    = 0;
    localparam int B_FUND_NL     = 1;
    localparam int B_APP_NL      = 2;
    localparam int B_ZX_FIRST    = 3;
    localparam logic [31:0] STATUS_SECOND_USED = 32'h0000_01ff;
    // Power polarity register bits.
    localparam int B_PATH2_POLAR = 7;
    localparam int B_PATH3_POLAR = 8;
    // Pulse mode register layout.
    localparam int PM_SEL_W      = 3;
    localparam int PM_DIS_LSB    = 9;
    localparam int PM_W          = 12;
    // Harmonic config register layout.
    localparam int HC_READY_BIT  = 0;
    localparam int HC_SETTLE_LSB = 3;
    localparam int HC_RATE_LSB   = 5;
    localparam int HC_W          = 8;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;

    // AHB transfer types.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    // AHB-Lite request from the master.
    typedef struct packed {
        logic        hsel;
        logic [31:0] haddr;
        logic [1:0]  htrans;
        logic        hwrite;
        logic [2:0]  hsize;
        logic [31:0] hwdata;
        logic        hready;
    } mesf_ahb_req_t;

    // AHB-Lite answer from the slave.
    typedef struct packed {
        logic        hreadyout;
        logic        hresp;
        logic [31:0] hrdata;
    } mesf_ahb_rsp_t;

    // Whole state of the block.
    typedef struct packed {
        logic [31:0]      status_first;
        logic [31:0]      status_second;
        logic [31:0]      mask_first;
        logic [31:0]      mask_second;
        logic [PM_W-1:0]  pulse_mode;
        logic [HC_W-1:0]  harm_config;
        logic             path2_polarity;
        logic             path3_polarity;
        logic [8:0]       noload_phases;
        logic [2:0][2:0]  pulse_cnt;
        logic [12:0]      tick_cnt;
        logic [13:0]      settle_cnt;
        logic             harm_armed;
        logic [5:0][7:0]  zx_cnt;
        logic             wr_pend;
        logic [15:0]      wr_idx;
        logic [31:0]      hrdata;
    } mesf_state_t;
endpackage

// *** core/mesf_top.sv ***
// Metering event status flags with AHB-Lite register access and interrupt.
// Summary of operation
// [R1] Path-two summed power sign change sets flag 13; polarity bit 7 shows it.
// [R2] Pulse output one falling edge sets flag 14, even when disabled.
// [R3] Pulse output two falling edge sets flag 15, even when disabled.
// [R4] Pulse output three falling edge sets flag 16, even when disabled.
// [R5] Three-bit source selects per pulse output at bits 2:0, 5:3, 8:6.
// [R6] Each completed 8 kHz processing cycle sets flag 17.
// [R7] Path-three summed power sign change sets flag 18; polarity bit 8 shows it.
// [R8] Ready mode clear: harmonic updates flag only after the chosen settle time.
// [R9] Ready mode set: harmonic updates flag immediately after setup.
// [R10] Reserved upper bits of the first status register read zero.
// [R11] Total no-load entry on any phase sets flag 0; phases in bits 2:0.
// [R12] Fundamental no-load entry sets flag 1; phases in bits 5:3.
// [R13] Apparent no-load entry sets flag 2; phases in bits 8:6.
// [R14] Missing voltage zero crossings on A, B, C set flags 3, 4, 5.
// [R15] Missing phase A current zero crossing sets flag 6.
// [R16] Missing phase B and C current zero crossings set flags 7, 8.
// [R17] Flags stay set until software writes one; writing zero keeps them.
//
// Local design decision: register access over AHB-Lite.
module mesf_top #(
    parameter int SAMPLE_CYCLES = mesf_pkg::SAMPLE_CYC
) (
    input  wire logic                    clk_in,
    input  wire logic                    reset_n_in,
    input  wire mesf_pkg::mesf_ahb_req_t ahb_req_in,
    output mesf_pkg::mesf_ahb_rsp_t      ahb_rsp_out,
    input  wire logic                    path2_sum_polarity_in,
    input  wire logic                    path3_sum_polarity_in,
    input  wire logic [2:0]              pulse_req_in,
    output logic [2:0]                   pulse_out_n_out,
    output logic [8:0]                   pulse_source_sel_out,
    output logic                         sample_tick_out,
    input  wire logic                    harmonic_setup_in,
    input  wire logic                    harmonic_update_in,
    output logic [2:0]                   harmonic_update_rate_out,
    input  wire logic [2:0]              total_noload_phases_in,
    input  wire logic [2:0]              fundamental_noload_phases_in,
    input  wire logic [2:0]              apparent_noload_phases_in,
    input  wire logic [5:0]              zero_crossing_in,
    output logic                         irq_out
);
    import mesf_pkg::*;

    localparam logic [12:0] TICK_LAST  = 13'(SAMPLE_CYCLES - 1);
    localparam logic [2:0]  PULSE_LAST = 3'(PULSE_LOW_CYC);
    localparam logic [7:0]  ZX_LAST    = 8'(ZX_TIMEOUT_TICKS);

    logic        rst_meta;
    logic        rst_n;
    mesf_state_t q;
    mesf_state_t d;
    logic        tick;
    logic [5:0]  zx_expire;
    logic [5:0][7:0] next_zx;
    logic [13:0] settle_target;
    logic        ahb_take;
    logic [15:0] addr_idx;
    logic        addr_ok;
    logic [31:0] rd_word;
    logic [31:0] wr_hit_first;
    logic [31:0] wr_hit_second;
    logic [31:0] set_first;
    logic [31:0] set_second;
    logic [8:0]  noload_now;

    // Two-stage release of the asynchronous reset.
    always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    assign tick          = (q.tick_cnt == TICK_LAST);
    assign noload_now    = {apparent_noload_phases_in, fundamental_noload_phases_in,
                            total_noload_phases_in};
    assign ahb_take      = ahb_req_in.hsel && ahb_req_in.hready && ahb_req_in.htrans[1];
    assign addr_idx      = ahb_req_in.haddr[17:2];
    assign addr_ok       = (ahb_req_in.haddr[31:18] == 14'h0000)
                           && (ahb_req_in.haddr[1:0] == 2'h0);

    // Settle time chosen by the settle-time code, converted to sample ticks.
    always_comb begin
        case (q.harm_config[HC_SETTLE_LSB +: 2])
            2'h0:    settle_target = 14'(SETTLE_MS_0 * TICKS_PER_MS);
            2'h1:    settle_target = 14'(SETTLE_MS_1 * TICKS_PER_MS);
            2'h2:    settle_target = 14'(SETTLE_MS_2 * TICKS_PER_MS);
            default: settle_target = 14'(SETTLE_MS_3 * TICKS_PER_MS);
        endcase
    end

    // Missing zero-crossing watchdogs, one per voltage and current channel.
    genvar ch;
    generate
        for (ch = 0; ch < 6; ch++) begin : g_zx
            // [R14] [R15] [R16] Timeout without a crossing.
            assign zx_expire[ch] = tick && !zero_crossing_in[ch] && (q.zx_cnt[ch] == ZX_LAST);
            assign next_zx[ch]   = (zero_crossing_in[ch] || zx_expire[ch]) ? 8'h00
                                   : (tick ? q.zx_cnt[ch] + 8'h01 : q.zx_cnt[ch]);
        end
    endgenerate

    // Read multiplexer, decoded during the address phase.
    always_comb begin
        rd_word = RESET_WORD;
        if (!addr_ok) begin
            rd_word = RESET_WORD;
        end else if (addr_idx == IDX_STATUS_FIRST) begin
            // [R10] Reserved bits read zero.
            rd_word = q.status_first & STATUS_FIRST_USED;
        end else if (addr_idx == IDX_STATUS_SECOND) begin
            rd_word = q.status_second & STATUS_SECOND_USED;
        end else if (addr_idx == IDX_MASK_FIRST) begin
            rd_word = q.mask_first;
        end else if (addr_idx == IDX_MASK_SECOND) begin
            rd_word = q.mask_second;
        end else if (addr_idx == IDX_NOLOAD_PHASE) begin
            rd_word = {23'h000000, q.noload_phases};
        end else if (addr_idx == IDX_PULSE_MODE) begin
            rd_word = {20'h00000, q.pulse_mode};
        end else if (addr_idx == IDX_POWER_POLAR) begin
            rd_word[B_PATH2_POLAR] = q.path2_polarity;
            rd_word[B_PATH3_POLAR] = q.path3_polarity;
        end else if (addr_idx == IDX_HARM_CONFIG) begin
            rd_word = {24'h000000, q.harm_config};
        end
    end

    // Hardware event sources for both status registers.
    always_comb begin
        set_first  = RESET_WORD;
        set_second = RESET_WORD;
        // [R1] Path-two sign change.
        set_first[B_PATH2_FLIP] = (path2_sum_polarity_in != q.path2_polarity);
        // [R2] [R3] [R4] Pulse start, regardless of disable.
        set_first[B_PULSE_ONE +: 3] = pulse_req_in;
        // [R6] Processing cycle done.
        set_first[B_DSP_DONE] = tick;
        // [R7] Path-three sign change.
        set_first[B_PATH3_FLIP] = (path3_sum_polarity_in != q.path3_polarity);
        // [R8] [R9] Harmonic update gated by arming.
        set_first[B_HARM_UPDATE] = harmonic_update_in && q.harm_armed && !harmonic_setup_in;
        // [R11] [R12] [R13] Any phase entering no-load.
        set_second[B_TOTAL_NL] = |(total_noload_phases_in & ~q.noload_phases[2:0]);
        set_second[B_FUND_NL]  = |(fundamental_noload_phases_in & ~q.noload_phases[5:3]);
        set_second[B_APP_NL]   = |(apparent_noload_phases_in & ~q.noload_phases[8:6]);
        // [R14] [R15] [R16] Missing crossings.
        set_second[B_ZX_FIRST +: 6] = zx_expire;
    end

    // Write strobes for the one-to-clear status bits.
    assign wr_hit_first  = (q.wr_pend && q.wr_idx == IDX_STATUS_FIRST)
                           ? ahb_req_in.hwdata : RESET_WORD;
    assign wr_hit_second = (q.wr_pend && q.wr_idx == IDX_STATUS_SECOND)
                           ? ahb_req_in.hwdata : RESET_WORD;

    // Next-state logic for the whole state; watchdog counters are copied from next_zx.
    always_comb begin
        d.pulse_mode     = q.pulse_mode;
        d.harm_config    = q.harm_config;
        d.mask_first     = q.mask_first;
        d.mask_second    = q.mask_second;
        d.path2_polarity = path2_sum_polarity_in;
        d.path3_polarity = path3_sum_polarity_in;
        d.noload_phases  = noload_now;
        d.tick_cnt       = tick ? 13'h0000 : q.tick_cnt + 13'h0001;
        d.zx_cnt         = next_zx;
        // [R17] Set wins over a one-to-clear write in the same cycle.
        d.status_first   = ((q.status_first & ~wr_hit_first) | set_first) & STATUS_FIRST_USED;
        d.status_second  = ((q.status_second & ~wr_hit_second) | set_second)
                           & STATUS_SECOND_USED;
        // Register writes land in the data phase.
        if (q.wr_pend) begin
            if (q.wr_idx == IDX_MASK_FIRST) begin
                d.mask_first = ahb_req_in.hwdata & STATUS_FIRST_USED;
            end else if (q.wr_idx == IDX_MASK_SECOND) begin
                d.mask_second = ahb_req_in.hwdata & STATUS_SECOND_USED;
            end else if (q.wr_idx == IDX_PULSE_MODE) begin
                d.pulse_mode = ahb_req_in.hwdata[PM_W-1:0];
            end else if (q.wr_idx == IDX_HARM_CONFIG) begin
                d.harm_config = ahb_req_in.hwdata[HC_W-1:0];
            end
        end
        // [R8] [R9] Settling after setup, skipped in ready mode.
        d.settle_cnt = q.settle_cnt;
        d.harm_armed = q.harm_armed;
        if (harmonic_setup_in) begin
            d.settle_cnt = 14'h0000;
            d.harm_armed = q.harm_config[HC_READY_BIT];
        end else if (!q.harm_armed && tick) begin
            d.settle_cnt = q.settle_cnt + 14'h0001;
            d.harm_armed = (q.settle_cnt + 14'h0001 >= settle_target);
        end
        // Active-low pulse timers; a request while busy is absorbed.
        for (int i = 0; i < 3; i++) begin
            if (pulse_req_in[i] && q.pulse_cnt[i] == 3'h0) begin
                d.pulse_cnt[i] = PULSE_LAST;
            end else if (q.pulse_cnt[i] != 3'h0) begin
                d.pulse_cnt[i] = q.pulse_cnt[i] - 3'h1;
            end else begin
                d.pulse_cnt[i] = 3'h0;
            end
        end
        // Bus address phase capture.
        d.wr_pend = ahb_take && ahb_req_in.hwrite && addr_ok;
        d.wr_idx  = addr_idx;
        d.hrdata  = (ahb_take && !ahb_req_in.hwrite) ? rd_word : q.hrdata;
    end

    // Single state register.
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    // Pin and bus outputs.
    always_comb begin
        ahb_rsp_out.hreadyout = 1'b1;
        ahb_rsp_out.hresp     = 1'b0;
        ahb_rsp_out.hrdata    = q.hrdata;
        for (int i = 0; i < 3; i++) begin
            // Pulse pin stays high when its disable bit is set.
            pulse_out_n_out[i] = !((q.pulse_cnt[i] != 3'h0) && !q.pulse_mode[PM_DIS_LSB + i]);
        end
    end
    // [R5] Source selects drive the power mux of each pulse path.
    assign pulse_source_sel_out     = q.pulse_mode[3*PM_SEL_W-1:0];
    assign harmonic_update_rate_out = q.harm_config[HC_RATE_LSB +: 3];
    assign sample_tick_out          = tick;
    assign irq_out = |(q.status_first & q.mask_first) || |(q.status_second & q.mask_second);

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n);

    sequence s_pulse_start(int i);
        pulse_req_in[i] && q.pulse_cnt[i] == 3'h0 && !q.pulse_mode[PM_DIS_LSB + i];
    endsequence
    sequence s_pulse_low(int i);
        !pulse_out_n_out[i] [*4] ##1 pulse_out_n_out[i];
    endsequence

    a_path2_flip_flag: assert property ( // [R1]
        (path2_sum_polarity_in != q.path2_polarity) |=> q.status_first[B_PATH2_FLIP]
            && q.path2_polarity == $past(path2_sum_polarity_in))
        else $error("Path two sign change not flagged.");
    a_pulse_one_flag: assert property ( // [R2]
        pulse_req_in[0] |=> q.status_first[B_PULSE_ONE])
        else $error("Pulse one start not flagged.");
    a_pulse_two_low: assert property ( // [R3]
        s_pulse_start(1) |=> s_pulse_low(1))
        else $error("Pulse two low phase has wrong width.");
    a_pulse_three_flag: assert property ( // [R4]
        pulse_req_in[2] && q.pulse_mode[PM_DIS_LSB + 2]
            |=> q.status_first[B_PULSE_ONE + 2] && pulse_out_n_out[2])
        else $error("Disabled pulse three misbehaved.");
    a_dsp_cycle_done: assert property ( // [R6]
        tick |=> q.status_first[B_DSP_DONE] && q.tick_cnt == 13'h0000)
        else $error("Processing cycle completion not flagged.");
    a_harm_unarmed: assert property ( // [R8]
        !q.harm_armed && !q.status_first[B_HARM_UPDATE]
            |=> !q.status_first[B_HARM_UPDATE])
        else $error("Harmonic flag set before settling.");
    a_harm_ready_mode: assert property ( // [R9]
        harmonic_setup_in && q.harm_config[HC_READY_BIT]
            ##1 harmonic_update_in && !harmonic_setup_in |=> q.status_first[B_HARM_UPDATE])
        else $error("Ready-mode harmonic update not flagged.");
    a_reserved_zero: assert property ( // [R10]
        ahb_take && !ahb_req_in.hwrite && addr_ok && addr_idx == IDX_STATUS_FIRST
            |=> ahb_rsp_out.hrdata[31:20] == 12'h000)
        else $error("Reserved status bits read nonzero.");
    a_noload_entry: assert property ( // [R11]
        (total_noload_phases_in & ~$past(total_noload_phases_in)) != 3'h0
            |=> q.status_second[B_TOTAL_NL])
        else $error("Total no-load entry not flagged.");
    a_zx_missing: assert property ( // [R15]
        zx_expire[3] |=> q.status_second[B_ZX_FIRST + 3] && q.zx_cnt[3] == 8'h00)
        else $error("Missing current crossing not flagged.");
    a_flag_sticky: assert property ( // [R17]
        q.status_second[B_APP_NL] && !wr_hit_second[B_APP_NL] |=> q.status_second[B_APP_NL])
        else $error("Status flag dropped without a clear.");
endmodule

// *** verif/tb_metering_event_status_flags.sv ***
// Self-checking testbench for the metering event status flag block over AHB-Lite.
module tb_metering_event_status_flags;
    timeunit 1ns;
    timeprecision 1ps;
    import mesf_pkg::*;

    localparam int SC = 16;

    logic          clk_in;
    logic          reset_n_in;
    logic          hsel;
    logic          hwrite;
    logic [31:0]   haddr;
    logic [31:0]   hwdata;
    logic [1:0]    htrans;
    logic [2:0]    hsize;
    mesf_ahb_req_t ahb_req;
    mesf_ahb_rsp_t ahb_rsp;
    logic          p2_pol;
    logic          p3_pol;
    logic [2:0]    pulse_req;
    logic [2:0]    pulse_n;
    logic [8:0]    src_sel;
    logic          tick;
    logic          h_setup;
    logic          h_update;
    logic [2:0]    h_rate;
    logic [2:0]    tnl;
    logic [2:0]    fnl;
    logic [2:0]    anl;
    logic [5:0]    zc;
    logic          irq;
    logic [31:0]   rd;
    logic [31:0]   exp_nl;
    int            failures;
    int            num_checks;
    int            n;

    // The one slave's ready is fed back as the bus ready.
    assign ahb_req = '{hsel: hsel, haddr: haddr, htrans: htrans, hwrite: hwrite,
                       hsize: hsize, hwdata: hwdata, hready: ahb_rsp.hreadyout};

    mesf_top #(.SAMPLE_CYCLES(SC)) dut (
        .clk_in                       (clk_in),
        .reset_n_in                   (reset_n_in),
        .ahb_req_in                   (ahb_req),
        .ahb_rsp_out                  (ahb_rsp),
        .path2_sum_polarity_in        (p2_pol),
        .path3_sum_polarity_in        (p3_pol),
        .pulse_req_in                 (pulse_req),
        .pulse_out_n_out              (pulse_n),
        .pulse_source_sel_out         (src_sel),
        .sample_tick_out              (tick),
        .harmonic_setup_in            (h_setup),
        .harmonic_update_in           (h_update),
        .harmonic_update_rate_out     (h_rate),
        .total_noload_phases_in       (tnl),
        .fundamental_noload_phases_in (fnl),
        .apparent_noload_phases_in    (anl),
        .zero_crossing_in             (zc),
        .irq_out                      (irq)
    );

    // Clock generator at 50 MHz.
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end

    // Waits for ready at a bounded number of rising edges.
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
        end while (ahb_rsp.hreadyout !== 1'b1 && k < 16);
        if (k >= 16) failures++;
    endtask

    // One single-word transfer; read data is taken at the data phase's last edge.
    task automatic bus_xfer(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
                            output logic [31:0] rdv);
        @(posedge clk_in);
        hsel   <= 1'b1;
        haddr  <= {14'h0, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        hsize  <= 3'h2;
        wait_ready();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wr ? wd : 32'h0;
        wait_ready();
        rdv = ahb_rsp.hrdata;
    endtask

    task automatic wr_reg(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] dummy;
        bus_xfer(1'b1, idx, d, dummy);
        // Let the register outputs settle before anyone looks at them.
        @(negedge clk_in);
    endtask

    task automatic rd_reg(input logic [15:0] idx, output logic [31:0] d);
        bus_xfer(1'b0, idx, 32'h0, d);
    endtask

    // Compares a value and counts the outcome.
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Asks one pulse and counts low cycles of that pin.
    task automatic pulse_count(input int i, output int cnt);
        @(posedge clk_in);
        pulse_req <= 3'(1 << i);
        @(posedge clk_in);
        pulse_req <= 3'h0;
        cnt = 0;
        repeat (10) begin
            @(negedge clk_in);
            if (pulse_n[i] === 1'b0) cnt++;
        end
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Watchdog against a hung handshake.
    initial begin
        #1_000_000;
        failures++;
        final_report();
    end

    // Main sequence of tests.
    initial begin
        failures = 0; num_checks = 0;
        reset_n_in = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 32'h0; hwdata = 32'h0;
        htrans = 2'h0; hsize = 3'h2; p2_pol = 1'b0; p3_pol = 1'b0; pulse_req = 3'h0;
        h_setup = 1'b0; h_update = 1'b0; tnl = 3'h0; fnl = 3'h0; anl = 3'h0; zc = 6'h0;
        repeat (6) @(posedge clk_in);
        reset_n_in <= 1'b1;
        repeat (4) @(posedge clk_in);
        check({31'h0, irq}, 32'h0);
        // Let one sample period pass so the cycle-done flag is up.
        repeat (SC) @(posedge clk_in);
        rd_reg(IDX_STATUS_FIRST, rd);
        check(rd, 32'h1 << B_DSP_DONE);
        rd_reg(IDX_MASK_SECOND, rd);
        check(rd, RESET_WORD);
        bus_xfer(1'b0, 16'h0, 32'h0, rd);
        check(rd, 32'h0);
        rd_reg(IDX_NOLOAD_PHASE, rd);
        check(rd, 32'h0);
        // Sample tick rate over four periods.
        n = 0;
        repeat (4 * SC) begin
            @(negedge clk_in);
            if (tick === 1'b1) n++;
        end
        check(32'(n), 32'h4);
        // Source selects, then enabled pulses of outputs one and two.
        wr_reg(IDX_PULSE_MODE, 32'h1d5);
        check({23'h0, src_sel}, 32'h1d5);
        pulse_count(0, n);
        check(32'(n), 32'(PULSE_LOW_CYC));
        pulse_count(1, n);
        check(32'(n), 32'(PULSE_LOW_CYC));
        // Disabled outputs two and three still raise their flags.
        wr_reg(IDX_PULSE_MODE, 32'hfd5);
        pulse_count(1, n);
        check(32'(n), 32'h0);
        pulse_count(2, n);
        check(32'(n), 32'h0);
        check({29'h0, pulse_n}, 32'h7);
        rd_reg(IDX_STATUS_FIRST, rd);
        check(rd & 32'h0001_c000, 32'h0001_c000);
        // Writing zero keeps flags, writing one clears only that flag.
        wr_reg(IDX_STATUS_FIRST, 32'h0);
        rd_reg(IDX_STATUS_FIRST, rd);
        check(rd & 32'h0001_c000, 32'h0001_c000);
        wr_reg(IDX_STATUS_FIRST, 32'h0000_4000);
        rd_reg(IDX_STATUS_FIRST, rd);
        check(rd & 32'hfff0_c000, 32'h0000_8000);
        // Sign changes of the summed path powers.
        @(posedge clk_in);
        p2_pol <= 1'b1;
        rd_reg(IDX_STATUS_FIRST, rd);
        check(rd & 32'h0004_2000, 32'h0000_2000);
        @(posedge clk_in);
        p3_pol <= 1'b1;
        rd_reg(IDX_STATUS_FIRST, rd);
        check(rd & 32'h0004_2000, 32'h0004_2000);
        rd_reg(IDX_POWER_POLAR, rd);
        check(rd, 32'h0000_0180);
        // No-load entry of phase B for each of the three judgements.
        exp_nl = 32'h0;
        for (int k = 0; k < 3; k++) begin
            @(posedge clk_in);
            if (k == 0) tnl <= 3'h2;
            if (k == 1) fnl <= 3'h2;
            if (k == 2) anl <= 3'h2;
            exp_nl = exp_nl | (32'h2 << (3 * k));
            rd_reg(IDX_STATUS_SECOND, rd);
            check(rd & 32'h7, 32'((2 << k) - 1));
            rd_reg(IDX_NOLOAD_PHASE, rd);
            check(rd, exp_nl);
        end
        // Crossings keep coming on voltage B only; the others time out.
        for (int k = 0; k < 45; k++) begin
            repeat (100) @(posedge clk_in);
            zc <= 6'h02;
            @(posedge clk_in);
            zc <= 6'h00;
            if (k == 0) wr_reg(IDX_STATUS_SECOND, 32'h1ff);
        end
        rd_reg(IDX_STATUS_SECOND, rd);
        check(rd, 32'h0000_01e8);
        // Interrupt follows unmasked status bits.
        wr_reg(IDX_MASK_SECOND, 32'h10);
        check({31'h0, irq}, 32'h0);
        wr_reg(IDX_MASK_SECOND, 32'h8);
        check({31'h0, irq}, 32'h1);
        wr_reg(IDX_STATUS_SECOND, 32'h8);
        check({31'h0, irq}, 32'h0);
        // Harmonic updates: unarmed while settling, armed at once in ready mode.
        wr_reg(IDX_HARM_CONFIG, 32'h0);
        @(posedge clk_in);
        h_setup <= 1'b1;
        @(posedge clk_in);
        h_setup <= 1'b0;
        repeat (2) @(posedge clk_in);
        h_update <= 1'b1;
        @(posedge clk_in);
        h_update <= 1'b0;
        rd_reg(IDX_STATUS_FIRST, rd);
        check(rd & 32'h0008_0000, 32'h0);
        wr_reg(IDX_HARM_CONFIG, 32'ha1);
        rd_reg(IDX_HARM_CONFIG, rd);
        check(rd, 32'ha1);
        check({29'h0, h_rate}, 32'h5);
        @(posedge clk_in);
        h_setup <= 1'b1;
        @(posedge clk_in);
        h_setup <= 1'b0;
        h_update <= 1'b1;
        @(posedge clk_in);
        h_update <= 1'b0;
        rd_reg(IDX_STATUS_FIRST, rd);
        check(rd & 32'hfff8_0000, 32'h0008_0000);
        final_report();
    end
endmodule
